// file: design/aec_core.sv
// encode qualification, strap decoding, coding and output strobe
`timescale 1ns/10ps
// Function
// - offset binary: full positive all ones, zero 0x200, full negative zeros
// - two's complement: zero is zeros, 0x1FF top, 0x200 bottom
// - out of range raises overrange flag and clamps to full-scale code
// - one code step per LSB, code rises monotonically with input
// - stabilizer samples on rising edge, makes own falling edge at half
// - stabilizer tolerates 20 to 80 percent external duty
// - after long encode stop, stabilizer needs about one hundred cycles to relock
// - result of a sample appears five encode cycles later
// - data updates just after strobe rises, capture on falling edge
// - strap ground or third gives offset binary, else two's complement
// - overrange flag high only when over or under range
module aec_core #(
  parameter int StopCount = aec_pkg::StopCycles
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic encode_pos_input,
  input wire logic encode_neg_input,
  input wire logic [1:0] modeStrap,
  input wire logic rangeStrap,
  input wire logic signed [11:0] analogSample,
  input wire logic [4:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  output logic [9:0] sample_code_bits,
  output logic overrange_flag,
  output logic sample_strobe_out,
  output logic dataValid,
  output logic twosCompMode,
  output logic stabilizerOn,
  output logic irq
);
  initial begin
    if (StopCount < 2) $error("stop count too small");
  end
  // ----------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------
  logic [1:0] rstPipe;
  logic rstSync_n;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) rstPipe <= 2'h0;
    else rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstSync_n = rstPipe[1];

  logic encDiff;
  assign encDiff = encode_pos_input & ~encode_neg_input;
  logic encMeta, encSync, encLast;
  logic [1:0] modeMeta, modeSync;
  logic rangeMeta, rangeSync;
  // two flops on each pin input, third flop for edge detection
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      encMeta <= 1'b0;
      encSync <= 1'b0;
      encLast <= 1'b0;
      modeMeta <= 2'h0;
      modeSync <= 2'h0;
      rangeMeta <= 1'b0;
      rangeSync <= 1'b0;
    end else begin
      encMeta <= encDiff;
      encSync <= encMeta;
      encLast <= encSync;
      modeMeta <= modeStrap;
      modeSync <= modeMeta;
      rangeMeta <= rangeStrap;
      rangeSync <= rangeMeta;
    end
  end
  logic encRise, encFall;
  assign encRise = encSync & ~encLast;
  assign encFall = ~encSync & encLast;

  // ----------------------------------------
  // strap decoding
  // ----------------------------------------
  // two's complement differs from offset binary only in the top bit; the
  // middle two strap levels also switch the stabilizer on
  function automatic logic isTwos(input logic [1:0] strap);
    return (strap == aec_pkg::StrapTwoThird) || (strap == aec_pkg::StrapSupply);
  endfunction
  function automatic logic isStab(input logic [1:0] strap);
    return (strap == aec_pkg::StrapThird) || (strap == aec_pkg::StrapTwoThird);
  endfunction
  logic twosNow, stabNow;
  assign twosNow = isTwos(modeSync);
  assign stabNow = isStab(modeSync);

  // ----------------------------------------
  // encode period measure and internal clock
  // ----------------------------------------
  logic [15:0] periodCnt, periodReg, phaseCnt;
  logic stopped;
  // measure rising to rising period, detect long stop
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      periodCnt <= 16'h0000;
      periodReg <= 16'h0000;
      stopped <= 1'b1;
    end else if (encRise) begin
      periodCnt <= 16'h0001;
      periodReg <= periodCnt;
      stopped <= 1'b0;
    end else if (periodCnt >= 16'(StopCount)) begin
      stopped <= 1'b1;
    end else begin
      periodCnt <= periodCnt + 16'h0001;
    end
  end
  logic intClk;
  // stabilizer makes the internal falling edge at half period, ignoring the pin
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      intClk <= 1'b0;
      phaseCnt <= 16'h0000;
    end else if (encRise) begin
      intClk <= 1'b1;
      phaseCnt <= 16'h0001;
    end else begin
      phaseCnt <= phaseCnt + 16'h0001;
      if (stabNow && (phaseCnt >= (periodReg >> 1))) intClk <= 1'b0;
      else if (!stabNow && encFall) intClk <= 1'b0;
    end
  end

  // ----------------------------------------
  // relock counting
  // ----------------------------------------
  logic [7:0] lockCnt;
  logic locked;
  // after a stop, count rising edges before results are valid
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      lockCnt <= 8'h00;
      locked <= 1'b0;
    end else if (stopped && stabNow) begin
      lockCnt <= 8'h00;
      locked <= 1'b0;
    end else if (!stabNow) begin
      locked <= 1'b1;
    end else if (encRise && !locked) begin
      lockCnt <= lockCnt + 8'h01;
      if (lockCnt >= 8'(aec_pkg::RelockCycles - 1)) locked <= 1'b1;
    end
  end

  // ----------------------------------------
  // quantise and code one sample
  // ----------------------------------------
  logic [9:0] obCode;
  logic overNow;
  // input counts 1V range steps: a 2V range step is two of them, so shift once
  always_comb begin
    logic signed [11:0] lsb;
    lsb = rangeSync ? (analogSample >>> 1) : analogSample;
    overNow = 1'b0;
    if (lsb > 12'sd511) begin
      obCode = aec_pkg::CodeMaxOb;
      overNow = 1'b1;
    end else if (lsb < -12'sd512) begin
      obCode = aec_pkg::CodeMinOb;
      overNow = 1'b1;
    end else begin
      obCode = 10'(lsb + 12'sd512);
    end
  end
  logic [9:0] codeNow;
  assign codeNow = twosNow ? {~obCode[9], obCode[8:0]} : obCode;

  logic [10:0] pipeOut;
  // one extra stage: a word leaves the pipe on the strobe that follows the
  // fifth rise after its sample, since the strobe lags the shifting rise
  aec_pipe #(.Width(11), .Depth(aec_pkg::PipeDepth + 1)) uPipe (
    .core_clk(core_clk),
    .rstSync_n(rstSync_n),
    .shiftEn(encRise),
    .dataIn({overNow, codeNow}),
    .dataOut(pipeOut)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic intClkLast;
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) intClkLast <= 1'b0;
    else intClkLast <= intClk;
  end
  // strobe is the delayed internal clock; data change on the same clock edge as its rise
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      sample_strobe_out <= 1'b0;
      sample_code_bits <= 10'h000;
      overrange_flag <= 1'b0;
      dataValid <= 1'b0;
    end else begin
      sample_strobe_out <= intClkLast;
      if (intClkLast && !sample_strobe_out) begin
        sample_code_bits <= pipeOut[9:0];
        overrange_flag <= pipeOut[10];
        dataValid <= locked;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      twosCompMode <= 1'b0;
      stabilizerOn <= 1'b0;
    end else begin
      twosCompMode <= twosNow;
      stabilizerOn <= stabNow;
    end
  end

  // ----------------------------------------
  // status, mask, interrupt and register port
  // ----------------------------------------
  localparam logic [4:0] AddrStatus = 5'h00;
  localparam logic [4:0] AddrMask = 5'h04;
  localparam logic [4:0] AddrState = 5'h08;
  logic [1:0] statusReg, maskReg, evt;
  logic lockedLast;
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) lockedLast <= 1'b0;
    else lockedLast <= locked;
  end
  assign evt = {overNow & encRise, locked & ~lockedLast};
  // sticky events, set wins over write-one clear
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) statusReg <= 2'h0;
    else if (regWrite && regAddr == AddrStatus) statusReg <= (statusReg & ~regWrData[1:0]) | evt;
    else statusReg <= statusReg | evt;
  end
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) maskReg <= 2'h0;
    else if (regWrite && regAddr == AddrMask) maskReg <= regWrData[1:0];
  end
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) irq <= 1'b0;
    else irq <= |(statusReg & maskReg);
  end
  // read data one cycle after the strobe, zero for unmapped addresses
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) regRdData <= 32'h0000_0000;
    else if (regRead) begin
      case (regAddr)
        AddrStatus: regRdData <= {30'h0, statusReg};
        AddrMask: regRdData <= {30'h0, maskReg};
        AddrState: regRdData <= {28'h0, rangeSync, locked, stabNow, twosNow};
        default: regRdData <= 32'h0000_0000;
      endcase
    end else regRdData <= 32'h0000_0000;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // helper: input above positive full scale in the selected range
  function automatic logic lsbOver();
    logic signed [11:0] v;
    v = rangeSync ? (analogSample >>> 1) : analogSample;
    return v > 12'sd511;
  endfunction
  // helper: input below negative full scale in the selected range
  function automatic logic lsbUnder();
    logic signed [11:0] v;
    v = rangeSync ? (analogSample >>> 1) : analogSample;
    return v < -12'sd512;
  endfunction

  // registered format flag follows the synchronised strap
  a_mode_decode: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    ##1 twosCompMode == $past(twosNow)) else $error("mode decode wrong");

  // input beyond positive full scale flags and clamps to the top code
  a_clamp_flag: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    lsbOver() |-> (overNow && obCode == aec_pkg::CodeMaxOb))
    else $error("overrange not flagged");
  a_clamp_under: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    lsbUnder() |-> (overNow && obCode == aec_pkg::CodeMinOb))
    else $error("underrange not flagged");

  // output word only moves together with a strobe rise
  a_data_step: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    $changed(sample_code_bits) |-> $rose(sample_strobe_out)) else $error("data moved off strobe");

  // flag only beside a full-scale word, in either coding
  a_flag_only: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    overrange_flag |-> (sample_code_bits[8:0] == 9'h1FF || sample_code_bits[8:0] == 9'h000))
    else $error("flag without full scale");

  // registered stabilizer flag follows the synchronised strap
  a_stab_mode: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    ##1 stabilizerOn == $past(stabNow)) else $error("stabilizer decode wrong");

  // a stopped encode with the stabilizer on drops lock on the next edge
  a_stop_unlock: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    (stopped && stabNow) |=> !locked) else $error("lock kept over a stop");

  // lock returns only after the full relock count of encode rises
  a_relock_count: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    ($rose(locked) && stabNow) |-> (lockCnt == 8'(aec_pkg::RelockCycles)))
    else $error("relock too early");

  // interrupt output is the registered or of the unmasked sticky bits
  a_irq_level: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    ##1 irq == $past(|(statusReg & maskReg))) else $error("interrupt level wrong");

  // an overrange event sets its sticky bit even beside a clearing write
  a_ovr_sticky: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    evt[1] |=> statusReg[1]) else $error("overrange event lost");

  // main scenarios
  c_over: cover property (@(posedge core_clk) $rose(overrange_flag));
  c_lock: cover property (@(posedge core_clk) $rose(locked));
  c_twos: cover property (@(posedge core_clk) twosCompMode && $rose(sample_strobe_out));
  c_stop: cover property (@(posedge core_clk) stopped && stabNow);
  c_under: cover property (@(posedge core_clk) overNow && obCode == aec_pkg::CodeMinOb);
endmodule

// file: inc/aec_pkg.sv
// shared constants for the encode and output coding block
package aec_pkg;
  localparam int DataWidth = 10;
  localparam int PipeDepth = 5;             // encode cycles from sample to output
  localparam int RelockCycles = 100;        // encode cycles to relock after a stop
  localparam real CorePeriodNs = 10.0;
  localparam real StopTimeNs = 2000.0;      // encode idle time counted as a stop
  localparam int StopCycles = int'(StopTimeNs / CorePeriodNs);
  localparam logic [9:0] CodeZeroOb = 10'h200;
  localparam logic [9:0] CodeMaxOb = 10'h3FF;
  localparam logic [9:0] CodeMinOb = 10'h000;
  localparam logic [1:0] StrapGnd = 2'h0;
  localparam logic [1:0] StrapThird = 2'h1;
  localparam logic [1:0] StrapTwoThird = 2'h2;
  localparam logic [1:0] StrapSupply = 2'h3;
  localparam logic [4:0] StatRelock = 5'h1;
endpackage

// file: design/aec_pipe.sv
// delay line for result words, output from a register
`timescale 1ns/10ps
module aec_pipe #(
  parameter int Width = 11,
  parameter int Depth = 5
) (
  input wire logic core_clk,
  input wire logic rstSync_n,
  input wire logic shiftEn,
  input wire logic [Width-1:0] dataIn,
  output logic [Width-1:0] dataOut
);
  initial begin
    if (Depth < 1) $error("depth must be at least one");
  end
  logic [Width-1:0] stage [Depth];
  // shift one stage per sample
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      for (int i = 0; i < Depth; i++) stage[i] <= '0;
    end else if (shiftEn) begin
      stage[0] <= dataIn;
      for (int i = 1; i < Depth; i++) stage[i] <= stage[i-1];
    end
  end
  assign dataOut = stage[Depth-1];
endmodule

// file: sim/aec_capture_model.sv
// capture model: latches the coded word on the falling edge of the output strobe
`timescale 1ns/10ps
module aec_capture_model (
  input wire logic sample_strobe_out,
  input wire logic [9:0] sample_code_bits,
  input wire logic overrange_flag,
  input wire logic dataValid,
  output logic [9:0] capCode,
  output logic capOvr,
  output logic capValid,
  output real hiNs
);
  realtime riseT = 0;
  // latch word and flag on strobe fall, the data settled just after the rise
  always @(negedge sample_strobe_out) begin
    capCode <= sample_code_bits;
    capOvr <= overrange_flag;
    capValid <= dataValid;
    hiNs <= $realtime - riseT;
  end
  // note the strobe rise to measure its high time
  always @(posedge sample_strobe_out) begin
    riseT = $realtime;
  end
endmodule

// file: sim/test_adc_encode_and_output_coding.sv
// testbench for the encode and output coding block
`timescale 1ns/10ps
module test_adc_encode_and_output_coding;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic encPos = 1'b0;
  logic encRun = 1'b0;
  logic [1:0] modeStrap = 2'h0;
  logic rangeStrap = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic signed [11:0] analogSample = 12'sh000;
  logic [4:0] regAddr = 5'h00;
  logic [31:0] regWrData = 32'h0;
  logic [31:0] regRdData;
  logic [9:0] code;
  logic [9:0] capCode;
  logic ovr, strobe, valid, twos, stab, irq, capOvr, capValid, stExp;
  real hiNs;
  int n_fail = 0;
  int check_count = 0;
  int dutyHi = 63;
  int vals[9] = '{0, 1, -1, -2, 511, 512, -512, -513, 2047};
  // core clock, 100 MHz
  always #5 core_clk = ~core_clk;
  // encode source, 125 ns period, idle low while stopped
  always begin
    if (encRun) begin
      encPos = 1'b1;
      #(dutyHi);
      encPos = 1'b0;
      #(125 - dutyHi);
    end else #7;
  end
  aec_core #(.StopCount(20)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
    .encode_pos_input(encPos), .encode_neg_input(~encPos), .modeStrap(modeStrap),
    .rangeStrap(rangeStrap), .analogSample(analogSample), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .sample_code_bits(code), .overrange_flag(ovr),
    .sample_strobe_out(strobe), .dataValid(valid), .twosCompMode(twos),
    .stabilizerOn(stab), .irq(irq));
  aec_capture_model u_cap (.sample_strobe_out(strobe), .sample_code_bits(code),
    .overrange_flag(ovr), .dataValid(valid), .capCode(capCode), .capOvr(capOvr),
    .capValid(capValid), .hiNs(hiNs));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 chk(regRdData & m, e);
  endtask
  task automatic waitFalls(input int n);
    repeat (n) @(negedge strobe);
    #1;
  endtask
  task automatic irqChk(input logic e);
    repeat (2) @(posedge core_clk);
    #1 chk({31'h0, irq}, {31'h0, e});
  endtask
  // expected overrange flag and coded word for a value in LSB units
  function automatic logic [10:0] expCode(input int v, input logic tw);
    int c = v + 512;
    logic ov = (c > 1023) || (c < 0);
    if (c > 1023) c = 1023;
    if (c < 0) c = 0;
    return {ov, c[9:0] ^ {tw, 9'h000}};
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog
  initial begin
    #500000;
    n_fail++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdc(5'h10, 32'hFFFFFFFF, 32'h0);
    encRun = 1'b1;
    for (int s = 0; s < 4; s++) begin
      modeStrap <= s[1:0];
      stExp = (s == 1) || (s == 2);
      dutyHi = (s == 1) ? 25 : 63;
      for (int i = 0; i < 9; i++) begin
        analogSample <= 12'(vals[i]);
        waitFalls(8);
        chk({capOvr, capCode}, expCode(vals[i], s[1]));
      end
      chk({twos, stab}, {s[1], stExp});
      rdc(5'h08, 32'hB, {28'h0, 1'b0, 1'b0, stExp, s[1]});
      if (s == 1) chk(hiNs > 55.0 && hiNs < 70.0, 1);
    end
    rangeStrap <= 1'b1;
    analogSample <= 12'sh3FE;
    waitFalls(8);
    chk({capOvr, capCode}, expCode(511, 1'b1));
    analogSample <= 12'sh401;
    waitFalls(8);
    chk({capOvr, capCode}, expCode(512, 1'b1));
    rdc(5'h08, 32'h9, 32'h9);
    rangeStrap <= 1'b0;
    analogSample <= 12'sh000;
    waitFalls(8);
    @(posedge encPos);
    @(posedge core_clk);
    analogSample <= 12'sh005;
    waitFalls(5);
    chk({capOvr, capCode}, expCode(0, 1'b1));
    waitFalls(1);
    chk({capOvr, capCode}, expCode(5, 1'b1));
    modeStrap <= 2'h1;
    waitFalls(120);
    wr(5'h00, 32'h3);
    wr(5'h04, 32'h0);
    irqChk(1'b0);
    encRun = 1'b0;
    #1000 encRun = 1'b1;
    waitFalls(3);
    chk(capValid, 0);
    waitFalls(110);
    chk(capValid, 1);
    rdc(5'h00, 32'h3, 32'h1);
    irqChk(1'b0);
    wr(5'h04, 32'h1);
    irqChk(1'b1);
    wr(5'h00, 32'h1);
    rdc(5'h00, 32'h1, 32'h0);
    irqChk(1'b0);
    test_done;
  end
endmodule
